/* File: include/sfb_pkg.sv */
// Purpose: Shared constants of the bank-1 special register block
// Assumes: APB index = byte address / 4, eight-bit registers
// Notes:   Each index below is the printed location of a register
package sfb_pkg;
   // ***************************************************
   // Register indices
   // ***************************************************
   localparam logic [7:0] IDX_INDIRECT = 8'h80;
   localparam logic [7:0] IDX_OPTION   = 8'h81;
   localparam logic [7:0] IDX_PC_LO    = 8'h82;
   localparam logic [7:0] IDX_STATUS   = 8'h83;
   localparam logic [7:0] IDX_POINTER  = 8'h84;
   localparam logic [7:0] IDX_DIR_A    = 8'h85;
   localparam logic [7:0] IDX_DIR_B    = 8'h86;
   localparam logic [7:0] IDX_DIR_C    = 8'h87;
   localparam logic [7:0] IDX_PC_HI    = 8'h8A;
   localparam logic [7:0] IDX_INTCTL   = 8'h8B;
   localparam logic [7:0] IDX_RSTCAUSE = 8'h8E;
   localparam logic [7:0] IDX_EVT_STAT = 8'h90;
   localparam logic [7:0] IDX_EVT_MASK = 8'h91;
   // ***************************************************
   // Widths and field positions
   // ***************************************************
   localparam int W_DIR_A    = 5;
   localparam int W_PC_HI    = 5;
   localparam int W_EV       = 3;
   localparam int POS_POR    = 1;
   localparam int EV_POR     = 0;
   localparam int EV_PIN     = 1;
   localparam int EV_WDT     = 2;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] RST_OPTION  = 8'hFF;
   localparam logic [7:0] RST_PC_LO   = 8'h00;
   localparam logic [7:0] RST_STATUS  = 8'h18;
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [4:0] RST_DIR_A   = 5'h1F;
   localparam logic [7:0] RST_DIR_B   = 8'hFF;
   localparam logic [7:0] RST_DIR_C   = 8'hFF;
   localparam logic [4:0] RST_PC_HI   = 5'h00;
   localparam logic [7:0] RST_INTCTL  = 8'h00;
   localparam logic       RST_POR     = 1'b0;
   localparam logic [2:0] RST_EV_STAT = 3'h1;
   localparam logic [2:0] RST_EV_MASK = 3'h0;
   localparam logic [1:0] RST_SYNC    = 2'h2;
endpackage : sfb_pkg

/* File: src/sfb_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous inputs
// Assumes: Inputs are slow levels or wide pulses
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module sfb_sync #(
   parameter int             W       = 2,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfb_sync_st_t;

   sfb_sync_st_t st_r;
   sfb_sync_st_t st_nxt;

   // Stage one feeds stage two only
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   // Both stages start at the idle level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= {RST_VAL, RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule : sfb_sync

/* File: src/sfb_events.sv */
// Purpose: Sticky reset-cause events, mask and interrupt line
// Assumes: Clear bits come from a read of the status register
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ps
module sfb_events (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic [sfb_pkg::W_EV-1:0] ev_set,
   input  wire logic [sfb_pkg::W_EV-1:0] clr_bits,
   input  wire logic                     mask_we,
   input  wire logic [sfb_pkg::W_EV-1:0] mask_wdata,
   output logic      [sfb_pkg::W_EV-1:0] ev_status,
   output logic      [sfb_pkg::W_EV-1:0] ev_mask,
   output logic                          irq
);
   typedef struct packed {
      logic [sfb_pkg::W_EV-1:0] stat;
      logic [sfb_pkg::W_EV-1:0] mask;
   } sfb_ev_st_t;

   sfb_ev_st_t st_r;
   sfb_ev_st_t st_nxt;

   // Clear first, then set, so no event is lost
   always_comb begin
      st_nxt      = st_r;
      st_nxt.stat = (st_r.stat & ~clr_bits) | ev_set;
      if (mask_we) begin
         st_nxt.mask = mask_wdata;
      end
   end

   // Power-on event is pending straight out of reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= {sfb_pkg::RST_EV_STAT, sfb_pkg::RST_EV_MASK};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ev_status = st_r.stat;
   assign ev_mask   = st_r.mask;
   assign irq       = |(st_r.stat & st_r.mask);
endmodule : sfb_events

/* File: src/sfb_bank1.sv */
// Purpose: Bank-1 special registers with reset-cause flag, APB slave
// Assumes: APB3 without strobes, low byte of pwdata carries data
// Notes:   Register index = paddr[9:2]; upper address bits must be 0
`timescale 1ns/1ps
module sfb_bank1 (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_reset_pin_n,
   input  wire logic        watchdog_timeout,
   output logic      [7:0]  timer_and_pullup_option,
   output logic      [7:0]  program_counter_low_byte,
   output logic      [7:0]  core_status_flags,
   output logic      [7:0]  indirect_address_pointer,
   output logic      [4:0]  port_a_direction,
   output logic      [7:0]  port_b_direction,
   output logic      [7:0]  port_c_direction,
   output logic      [4:0]  program_counter_high_latch,
   output logic      [7:0]  interrupt_control_flags,
   output logic             power_on_flag,
   output logic             irq
);
   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [7:0] option;
      logic [7:0] pc_lo;
      logic [7:0] status;
      logic [7:0] pointer;
      logic [4:0] dir_a;
      logic [7:0] dir_b;
      logic [7:0] dir_c;
      logic [4:0] pc_hi;
      logic [7:0] intctl;
      logic       por;
      logic [7:0] rdata;
      logic [2:0] rd_clr;
      logic       pin_d;
      logic       wdt_d;
   } sfb_main_st_t;

   sfb_main_st_t st_r;
   sfb_main_st_t st_nxt;

   logic [1:0] sync_q;
   logic       pin_n_s;
   logic       wdt_s;
   logic [2:0] ev_set;
   logic [2:0] clr_bits;
   logic       mask_we;
   logic [2:0] ev_status;
   logic [2:0] ev_mask;
   logic [7:0] idx;
   logic [7:0] eff;
   logic       mapped;
   logic       setup;
   logic       acc_wr;
   logic       acc_rd;
   logic       other_rst;
   logic       pin_edge;
   logic       wdt_edge;

   // ***************************************************
   // Functions
   // ***************************************************
   // Locations that hold a real register
   function automatic logic is_mapped(input logic [7:0] i);
      case (i)
         sfb_pkg::IDX_OPTION,   sfb_pkg::IDX_PC_LO,
         sfb_pkg::IDX_STATUS,   sfb_pkg::IDX_POINTER,
         sfb_pkg::IDX_DIR_A,    sfb_pkg::IDX_DIR_B,
         sfb_pkg::IDX_DIR_C,    sfb_pkg::IDX_PC_HI,
         sfb_pkg::IDX_INTCTL,   sfb_pkg::IDX_RSTCAUSE,
         sfb_pkg::IDX_EVT_STAT, sfb_pkg::IDX_EVT_MASK: begin
            is_mapped = 1'b1;
         end
         default: begin
            is_mapped = 1'b0;
         end
      endcase
   endfunction : is_mapped

   // Read value; narrow registers pad with zero
   function automatic logic [7:0] rd_val(
      input sfb_main_st_t s,
      input logic [7:0]   i,
      input logic [2:0]   es,
      input logic [2:0]   em
   );
      logic [7:0] v;
      v = 8'h00;
      case (i)
         sfb_pkg::IDX_OPTION:   v = s.option;
         sfb_pkg::IDX_PC_LO:    v = s.pc_lo;
         sfb_pkg::IDX_STATUS:   v = s.status;
         sfb_pkg::IDX_POINTER:  v = s.pointer;
         sfb_pkg::IDX_DIR_A:    v = {3'h0, s.dir_a};
         sfb_pkg::IDX_DIR_B:    v = s.dir_b;
         sfb_pkg::IDX_DIR_C:    v = s.dir_c;
         sfb_pkg::IDX_PC_HI:    v = {3'h0, s.pc_hi};
         sfb_pkg::IDX_INTCTL:   v = s.intctl;
         sfb_pkg::IDX_RSTCAUSE: v[sfb_pkg::POS_POR] = s.por;
         sfb_pkg::IDX_EVT_STAT: v = {5'h00, es};
         sfb_pkg::IDX_EVT_MASK: v = {5'h00, em};
         default:               v = 8'h00;
      endcase
      return v;
   endfunction : rd_val

   // ***************************************************
   // Reset-cause inputs
   // ***************************************************
   // Pin and watchdog come from outside the clock domain
   sfb_sync #(
      .W       (2),
      .RST_VAL (sfb_pkg::RST_SYNC)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({external_reset_pin_n, watchdog_timeout}),
      .q      (sync_q)
   );

   // Pin holds the bank in reset; watchdog acts on its edge
   assign pin_n_s   = sync_q[1];
   assign wdt_s     = sync_q[0];
   assign pin_edge  = st_r.pin_d & ~pin_n_s;
   assign wdt_edge  = wdt_s & ~st_r.wdt_d;
   assign other_rst = ~pin_n_s | wdt_edge;

   // ***************************************************
   // APB decode
   // ***************************************************
   // Indirect slot is replaced by the pointer before decode
   assign idx    = paddr[9:2];
   assign eff    = (idx == sfb_pkg::IDX_INDIRECT) ?
                   st_r.pointer : idx;
   assign mapped = (paddr[11:10] == 2'h0) & is_mapped(eff);
   assign setup  = psel & ~penable;
   assign acc_wr = psel & penable & pwrite;
   assign acc_rd = psel & penable & ~pwrite;

   // Zero wait: read data is caught in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = {24'h000000, st_r.rdata};

   // ***************************************************
   // Register next state
   // ***************************************************
   always_comb begin
      st_nxt       = st_r;
      ev_set       = 3'h0;
      clr_bits     = 3'h0;
      mask_we      = 1'b0;
      st_nxt.pin_d = pin_n_s;
      st_nxt.wdt_d = wdt_s;
      ev_set[sfb_pkg::EV_PIN] = pin_edge;
      ev_set[sfb_pkg::EV_WDT] = wdt_edge;
      // Only bits actually shown to software get cleared
      if (setup) begin
         st_nxt.rdata  = mapped ?
            rd_val(st_r, eff, ev_status, ev_mask) : 8'h00;
         st_nxt.rd_clr =
            (mapped && eff == sfb_pkg::IDX_EVT_STAT) ?
            ev_status : 3'h0;
      end
      if (acc_rd) begin
         clr_bits = st_r.rd_clr;
      end
      if (other_rst) begin
         // Other-class reset; power-on flag is left alone
         st_nxt.option  = sfb_pkg::RST_OPTION;
         st_nxt.pc_lo   = sfb_pkg::RST_PC_LO;
         st_nxt.status  = sfb_pkg::RST_STATUS;
         st_nxt.pointer = sfb_pkg::RST_POINTER;
         st_nxt.dir_a   = sfb_pkg::RST_DIR_A;
         st_nxt.dir_b   = sfb_pkg::RST_DIR_B;
         st_nxt.dir_c   = sfb_pkg::RST_DIR_C;
         st_nxt.pc_hi   = sfb_pkg::RST_PC_HI;
         st_nxt.intctl  = sfb_pkg::RST_INTCTL;
         st_nxt.por     = st_r.por;
      end else if (acc_wr && mapped) begin
         // Reserved status and control bits are kept as written;
         // keeping them clear is up to software
         case (eff)
            sfb_pkg::IDX_OPTION:  st_nxt.option  = pwdata[7:0];
            sfb_pkg::IDX_PC_LO:   st_nxt.pc_lo   = pwdata[7:0];
            sfb_pkg::IDX_STATUS:  st_nxt.status  = pwdata[7:0];
            sfb_pkg::IDX_POINTER: st_nxt.pointer = pwdata[7:0];
            sfb_pkg::IDX_DIR_A:   st_nxt.dir_a   = pwdata[4:0];
            sfb_pkg::IDX_DIR_B:   st_nxt.dir_b   = pwdata[7:0];
            sfb_pkg::IDX_DIR_C:   st_nxt.dir_c   = pwdata[7:0];
            sfb_pkg::IDX_PC_HI:   st_nxt.pc_hi   = pwdata[4:0];
            sfb_pkg::IDX_INTCTL:  st_nxt.intctl  = pwdata[7:0];
            sfb_pkg::IDX_RSTCAUSE: begin
               st_nxt.por = pwdata[sfb_pkg::POS_POR];
            end
            sfb_pkg::IDX_EVT_MASK: mask_we = 1'b1;
            default: begin
            end
         endcase
      end
   end

   // Power-on reset is the only asynchronous reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r         <= '0;
         st_r.option  <= sfb_pkg::RST_OPTION;
         st_r.pc_lo   <= sfb_pkg::RST_PC_LO;
         st_r.status  <= sfb_pkg::RST_STATUS;
         st_r.pointer <= sfb_pkg::RST_POINTER;
         st_r.dir_a   <= sfb_pkg::RST_DIR_A;
         st_r.dir_b   <= sfb_pkg::RST_DIR_B;
         st_r.dir_c   <= sfb_pkg::RST_DIR_C;
         st_r.pc_hi   <= sfb_pkg::RST_PC_HI;
         st_r.intctl  <= sfb_pkg::RST_INTCTL;
         st_r.por     <= sfb_pkg::RST_POR;
         st_r.pin_d   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************
   // Interrupt events
   // ***************************************************
   sfb_events u_events (
      .clk        (clk),
      .resetn     (resetn),
      .ev_set     (ev_set),
      .clr_bits   (clr_bits),
      .mask_we    (mask_we),
      .mask_wdata (pwdata[2:0]),
      .ev_status  (ev_status),
      .ev_mask    (ev_mask),
      .irq        (irq)
   );

   // Register contents toward the core
   assign timer_and_pullup_option    = st_r.option;
   assign program_counter_low_byte   = st_r.pc_lo;
   assign core_status_flags          = st_r.status;
   assign indirect_address_pointer   = st_r.pointer;
   assign port_a_direction           = st_r.dir_a;
   assign port_b_direction           = st_r.dir_b;
   assign port_c_direction           = st_r.dir_c;
   assign program_counter_high_latch = st_r.pc_hi;
   assign interrupt_control_flags    = st_r.intctl;
   assign power_on_flag              = st_r.por;

   // ***************************************************
   // Assertions
   // ***************************************************
   chk_unmapped_zero: assert property (
      @(posedge clk) disable iff (!resetn)
      setup && !pwrite && !mapped |=> prdata == 32'h0)
      else $error("unmapped read not zero");

   chk_unmapped_nowr: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_wr && !mapped && !other_rst |=>
      $stable(st_r.option) && $stable(st_r.pointer) &&
      $stable(st_r.status) && $stable(st_r.por))
      else $error("unmapped write changed a register");

   chk_other_rst_val: assert property (
      @(posedge clk) disable iff (!resetn)
      other_rst |=> st_r.option == sfb_pkg::RST_OPTION &&
      st_r.dir_a == sfb_pkg::RST_DIR_A &&
      st_r.pc_lo == sfb_pkg::RST_PC_LO)
      else $error("other reset values wrong");

   chk_por_read: assert property (
      @(posedge clk) disable iff (!resetn)
      setup && !pwrite && idx == sfb_pkg::IDX_RSTCAUSE &&
      paddr[11:10] == 2'h0 |=>
      prdata[sfb_pkg::POS_POR] == $past(st_r.por))
      else $error("power-on flag read wrong");

   chk_rstcause_pad: assert property (
      @(posedge clk) disable iff (!resetn)
      setup && eff == sfb_pkg::IDX_RSTCAUSE |=>
      prdata[7:2] == 6'h00 && prdata[0] == 1'b0)
      else $error("reset-cause spare bits not zero");

   chk_por_write: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_wr && eff == sfb_pkg::IDX_RSTCAUSE && mapped &&
      !other_rst |=> st_r.por == $past(pwdata[sfb_pkg::POS_POR]))
      else $error("power-on flag write lost");

   chk_por_keep: assert property (
      @(posedge clk) disable iff (!resetn)
      other_rst |=> st_r.por == $past(st_r.por))
      else $error("power-on flag lost on other reset");

   chk_indirect_wr: assert property (
      @(posedge clk) disable iff (!resetn)
      acc_wr && idx == sfb_pkg::IDX_INDIRECT &&
      paddr[11:10] == 2'h0 &&
      st_r.pointer == sfb_pkg::IDX_OPTION && !other_rst |=>
      st_r.option == $past(pwdata[7:0]))
      else $error("indirect write missed target");

   cov_por_read: cover property (
      @(posedge clk) disable iff (!resetn)
      acc_rd && eff == sfb_pkg::IDX_RSTCAUSE && st_r.por);
   cov_indirect: cover property (
      @(posedge clk) disable iff (!resetn)
      acc_rd && idx == sfb_pkg::IDX_INDIRECT && mapped);
   cov_wdt_rst: cover property (
      @(posedge clk) disable iff (!resetn) wdt_edge && st_r.por);
   cov_irq: cover property (
      @(posedge clk) disable iff (!resetn) irq && acc_rd);
endmodule : sfb_bank1

/* File: tb/sfb_bank1_tb_top.sv */
// Purpose: Self-checking bench of the bank-1 special register block
// Assumes: APB answer comes when pready is high; no random stimulus
// Notes:   Other resets come from the pin and watchdog inputs
`timescale 1ns/1ps
module sfb_bank1_tb_top;
   // ***************************************************
   // Signals and tables
   // ***************************************************
   logic        clk                  = 1'b0;
   logic        resetn               = 1'b0;
   logic        psel                 = 1'b0;
   logic        penable              = 1'b0;
   logic        pwrite               = 1'b0;
   logic [11:0] paddr                = 12'h000;
   logic [31:0] pwdata               = 32'h00000000;
   logic        external_reset_pin_n = 1'b1;
   logic        watchdog_timeout     = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  opt_q;
   logic [7:0]  pc_lo_q;
   logic [7:0]  stat_q;
   logic [7:0]  ptr_q;
   logic [4:0]  dir_a;
   logic [7:0]  dir_b;
   logic [7:0]  dir_c;
   logic [4:0]  pch_q;
   logic [7:0]  intc_q;
   logic        power_on_flag;
   logic        irq;
   int          err_total            = 0;
   int          cmp_count            = 0;
   int          cycles               = 0;

   // Byte addresses of option .. reset cause, status at slot 2
   localparam logic [11:0] RA [10] = '{12'h204, 12'h208, 12'h20C,
      12'h210, 12'h214, 12'h218, 12'h21C, 12'h228, 12'h22C, 12'h238};
   localparam logic [7:0] RV [10] = '{sfb_pkg::RST_OPTION,
      sfb_pkg::RST_PC_LO, sfb_pkg::RST_STATUS, sfb_pkg::RST_POINTER,
      {3'h0, sfb_pkg::RST_DIR_A}, sfb_pkg::RST_DIR_B,
      sfb_pkg::RST_DIR_C, {3'h0, sfb_pkg::RST_PC_HI},
      sfb_pkg::RST_INTCTL, 8'h00};
   // Interrupt control written with its reserved bit 6 kept clear
   localparam logic [7:0] WV [10] = '{8'hFF, 8'hFF, 8'h00, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF};
   localparam logic [7:0] BV [10] = '{8'hFF, 8'hFF, 8'h18, 8'hFF,
      8'h1F, 8'hFF, 8'hFF, 8'h1F, 8'hBF, 8'h02};

   sfb_bank1 dut_u (
      .clk                        (clk),
      .resetn                     (resetn),
      .psel                       (psel),
      .penable                    (penable),
      .pwrite                     (pwrite),
      .paddr                      (paddr),
      .pwdata                     (pwdata),
      .prdata                     (prdata),
      .pready                     (pready),
      .pslverr                    (pslverr),
      .external_reset_pin_n       (external_reset_pin_n),
      .watchdog_timeout           (watchdog_timeout),
      .timer_and_pullup_option    (opt_q),
      .program_counter_low_byte   (pc_lo_q),
      .core_status_flags          (stat_q),
      .indirect_address_pointer   (ptr_q),
      .port_a_direction           (dir_a),
      .port_b_direction           (dir_b),
      .port_c_direction           (dir_c),
      .program_counter_high_latch (pch_q),
      .interrupt_control_flags    (intc_q),
      .power_on_flag              (power_on_flag),
      .irq                        (irq)
   );

   // ***************************************************
   // Clock, timeout and shared tasks
   // ***************************************************
   always #12.5 clk = ~clk;

   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'hFFFFFF, wd};
      @(posedge clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] v;
      apb(1'b1, a, d, v);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] v;
      apb(1'b0, a, 8'h00, v);
      chk($sformatf("read %h", a), v, {24'h000000, e});
   endtask : rd_chk

   task automatic power_on();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
   endtask : power_on

   // Pin held low or watchdog held high, then time to settle
   task automatic other_reset(input logic pin);
      @(posedge clk);
      if (pin) external_reset_pin_n <= 1'b0;
      else watchdog_timeout <= 1'b1;
      repeat (4) @(posedge clk);
      external_reset_pin_n <= 1'b1;
      watchdog_timeout     <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : other_reset

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset_values();
      for (int i = 0; i < 10; i++) rd_chk(RA[i], RV[i]);
      rd_chk(12'h220, 8'h00);
      chk("pslverr", {31'h0, pslverr}, 32'h0);
      rd_chk(12'h240, 8'h01);
      rd_chk(12'h240, 8'h00);
      chk("irq", {31'h0, irq}, 32'h0);
      chk("flag", {31'h0, power_on_flag}, 32'h0);
   endtask : t_reset_values

   // Status is left untouched so its bank-select bits stay clear
   task automatic t_write_all();
      for (int i = 0; i < 10; i++) if (i != 2) wr(RA[i], WV[i]);
      wr(12'h220, 8'hFF);
      // Upper address bits set: option must stay as written
      wr(12'h604, 8'h00);
      rd_chk(12'hA04, 8'h00);
      for (int i = 0; i < 10; i++) rd_chk(RA[i], BV[i]);
      rd_chk(12'h220, 8'h00);
      chk("dir a", {27'h0, dir_a}, 32'h1F);
      chk("option out", {24'h0, opt_q}, {24'h0, BV[0]});
      chk("pc low out", {24'h0, pc_lo_q}, {24'h0, BV[1]});
      chk("status out", {24'h0, stat_q}, {24'h0, BV[2]});
      chk("pointer out", {24'h0, ptr_q}, {24'h0, BV[3]});
      chk("dir b", {24'h0, dir_b}, {24'h0, BV[5]});
      chk("dir c", {24'h0, dir_c}, {24'h0, BV[6]});
      chk("pc high", {27'h0, pch_q}, {24'h0, BV[7]});
      chk("int ctl", {24'h0, intc_q}, {24'h0, BV[8]});
      chk("flag", {31'h0, power_on_flag}, 32'h1);
   endtask : t_write_all

   // Pin event unmasked, watchdog event masked
   task automatic t_other(input logic pin);
      wr(12'h244, 8'h02);
      wr(12'h204, 8'h00);
      other_reset(pin);
      rd_chk(12'h204, sfb_pkg::RST_OPTION);
      for (int i = 1; i < 9; i++) rd_chk(RA[i], RV[i]);
      rd_chk(12'h238, 8'h02);
      // Clear lands at the answer edge; look once it has settled
      @(negedge clk);
      chk("irq", {31'h0, irq}, {31'h0, pin});
      rd_chk(12'h240, pin ? 8'h02 : 8'h04);
      @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h0);
      rd_chk(12'h244, 8'h02);
   endtask : t_other

   task automatic t_indirect();
      wr(12'h210, 8'h81);
      wr(12'h200, 8'h5A);
      rd_chk(12'h204, 8'h5A);
      rd_chk(12'h200, 8'h5A);
      wr(12'h210, 8'h8E);
      rd_chk(12'h200, 8'h02);
      wr(12'h210, 8'h20);
      wr(12'h200, 8'h33);
      rd_chk(12'h200, 8'h00);
      rd_chk(12'h210, 8'h20);
   endtask : t_indirect

   task automatic t_second_por();
      power_on();
      rd_chk(12'h238, 8'h00);
      rd_chk(12'h204, sfb_pkg::RST_OPTION);
      rd_chk(12'h244, 8'h00);
      rd_chk(12'h240, 8'h01);
   endtask : t_second_por

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      power_on();
      t_reset_values();
      t_write_all();
      t_other(1'b1);
      t_other(1'b0);
      t_indirect();
      t_second_por();
      end_sim();
   end
endmodule : sfb_bank1_tb_top
